// ### rtl/ppio_pkg.sv
// types shared by the paged parallel port block
package ppio_pkg;
    typedef logic [7:0] ppio_byte_t;
    typedef struct packed {
        logic port_c_mode_select;
        logic port_a_mode_select;
        logic port_a_direction;
        logic dirCUpper;
        logic port_b_mode_select;
        logic port_b_direction;
        logic dirCLower;
    } ppio_cfg_s;
    typedef struct packed {
        ppio_byte_t portALines;
        ppio_byte_t portBLines;
        ppio_byte_t portCLines;
    } ppio_lines_s;
    typedef enum logic [1:0] {
        PPIO_HS_IDLE,
        PPIO_HS_ACK,
        PPIO_HS_WAIT_LOW
    } ppio_hs_e;
endpackage : ppio_pkg

// ### rtl/ppio_ports.sv
// three 8-bit parallel ports behind a paged byte-register window
// How it works
// RULE_01 - decode ports only on page 1, offsets 12-15
// RULE_02 - host selects page 1 before port access
// RULE_03 - page-only writes cause no resets
// RULE_04 - reset bit writes keep page unchanged
// RULE_05 - offset 7 returns current page
// RULE_06 - A, B whole; C as two halves
// RULE_07 - pin drivers follow latest config byte
// RULE_08 - all ports input after reset
// RULE_09 - offsets 12-14 are port data registers
// RULE_10 - offset 15 write-only config, bit7 set
// RULE_11 - direction bit 0 output, 1 input
// RULE_12 - mode bit selects mode 0 or 1
// RULE_13 - 9b all in, 80 all out, 92 C out
// RULE_14 - mode 0 reads sample pins, no handshake
// RULE_15 - mode 1 has latch in, ack out
// RULE_16 - port A input: latch edge captures, ack
// RULE_17 - port A output: write raises ack, latch lowers
// RULE_18 - interrupt held until bit 3 cleared
// RULE_19 - input lines undriven, writes not read back
`timescale 1ns/1ps
`include "ppio_regs.svh"
module ppio_ports (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] busAddr,
    input wire logic busRead,
    input wire logic busWrite,
    input wire ppio_pkg::ppio_byte_t busWdata,
    output ppio_pkg::ppio_byte_t busRdata,
    input wire ppio_pkg::ppio_lines_s linesIn,
    output ppio_pkg::ppio_lines_s linesOut,
    output ppio_pkg::ppio_lines_s linesOe_n,
    input wire logic latchIn,
    output logic ackOut,
    output logic irqOut,
    output logic boardResetPulse,
    output logic [2:0] pageOut
);
    import ppio_pkg::*;

    ppio_lines_s pinSync1_reg;
    ppio_lines_s pinSync2_reg;
    logic latchSync1_reg;
    logic latchSync2_reg;
    logic latchPrev_reg;
    logic [2:0] page_reg;
    ppio_cfg_s cfg_reg;
    ppio_byte_t portAOut_reg;
    ppio_byte_t portBOut_reg;
    ppio_byte_t portCOut_reg;
    ppio_byte_t portALatched_reg;
    ppio_hs_e hs_reg;
    ppio_hs_e hs_next;
    logic irq_reg;
    logic boardReset_reg;
    ppio_byte_t rdata_reg;
    ppio_lines_s oe_reg;
    logic pageSel;
    logic wrA;
    logic rdA;
    logic latchRise;
    logic latchHigh;
    logic modeOneIn;
    logic modeOneOut;
    logic hsEvent;
    ppio_byte_t cReadVal;
    ppio_byte_t readVal;
    logic wrMisc;
    logic wrCfg;
    logic wrPort;
    logic intClear;

    // header pins come from outside, so pass two flops first
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pinSync1_reg <= '0;
            pinSync2_reg <= '0;
        end else begin
            pinSync1_reg <= linesIn;
            pinSync2_reg <= pinSync1_reg;
        end
    end

    // strobe synchroniser; the previous copy resets low to match the idle strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            latchSync1_reg <= 1'b0;
            latchSync2_reg <= 1'b0;
            latchPrev_reg <= 1'b0;
        end else begin
            latchSync1_reg <= latchIn;
            latchSync2_reg <= latchSync1_reg;
            latchPrev_reg <= latchSync2_reg;
        end
    end

    assign latchHigh = latchSync2_reg;
    assign latchRise = latchSync2_reg & ~latchPrev_reg;
    assign pageSel = (page_reg == `PPIO_PAGE_PORTS); // RULE_01 RULE_02
    assign wrA = busWrite & pageSel & (busAddr == `PPIO_OFS_PORT_A);
    assign rdA = busRead & pageSel & (busAddr == `PPIO_OFS_PORT_A);
    assign modeOneIn = cfg_reg.port_a_mode_select & cfg_reg.port_a_direction; // RULE_12 RULE_16
    assign modeOneOut = cfg_reg.port_a_mode_select & ~cfg_reg.port_a_direction; // RULE_17
    assign wrMisc = busWrite & (busAddr == `PPIO_OFS_MISC_CTRL);
    assign intClear = wrMisc & busWdata[`PPIO_MISC_INT_CLEAR];
    assign wrCfg = busWrite & pageSel & (busAddr == `PPIO_OFS_CONFIG)
                   & busWdata[`PPIO_CFG_SET]; // RULE_10
    assign wrPort = busWrite & pageSel;

    // page field of the miscellaneous control register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            page_reg <= `PPIO_PAGE_RESET;
        end else if (wrMisc && !busWdata[`PPIO_MISC_BOARD_RESET]
                     && !busWdata[`PPIO_MISC_INT_CLEAR]) begin
            // page changes only when neither reset bit is set
            page_reg <= busWdata[`PPIO_MISC_PAGE_MSB:`PPIO_MISC_PAGE_LSB]; // RULE_03 RULE_04
        end
    end

    // board reset is a one-cycle pulse; a page-only write never raises it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            boardReset_reg <= 1'b0;
        end else begin
            boardReset_reg <= wrMisc & busWdata[`PPIO_MISC_BOARD_RESET]; // RULE_03
        end
    end

    // configuration byte; writes without the set bit are ignored
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_reg <= ppio_cfg_s'(7'(`PPIO_CFG_RESET)); // RULE_08
        end else if (wrCfg) begin
            cfg_reg <= ppio_cfg_s'(busWdata[6:0]); // RULE_10 RULE_13
        end
    end

    // output data holders, written regardless of direction
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            portAOut_reg <= `PPIO_DATA_RESET;
        end else if (wrA) begin
            portAOut_reg <= busWdata; // RULE_09
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            portBOut_reg <= `PPIO_DATA_RESET;
        end else if (wrPort && busAddr == `PPIO_OFS_PORT_B) begin
            portBOut_reg <= busWdata; // RULE_09
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            portCOut_reg <= `PPIO_DATA_RESET;
        end else if (wrPort && busAddr == `PPIO_OFS_PORT_C) begin
            portCOut_reg <= busWdata; // RULE_09
        end
    end

    // port A mode 1 input latch; a second edge before the read overwrites
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            portALatched_reg <= `PPIO_DATA_RESET;
        end else if (modeOneIn && latchRise) begin
            portALatched_reg <= pinSync2_reg.portALines; // RULE_16
        end else if (rdA) begin
            portALatched_reg <= `PPIO_DATA_RESET;
        end
    end

    // handshake sequencer for port A mode 1
    always_comb begin
        hs_next = hs_reg;
        hsEvent = 1'b0;
        case (hs_reg)
            PPIO_HS_IDLE: begin
                if (modeOneIn && latchRise) begin
                    hs_next = PPIO_HS_ACK; // RULE_15 RULE_16
                    hsEvent = 1'b1;
                end else if (modeOneOut && wrA) begin
                    hs_next = PPIO_HS_ACK; // RULE_17
                end
            end
            PPIO_HS_ACK: begin
                if (modeOneIn) begin
                    if (latchRise) begin
                        hsEvent = 1'b1;
                    end else if (rdA) begin
                        hs_next = PPIO_HS_IDLE; // RULE_16
                    end
                end else if (modeOneOut) begin
                    if (latchHigh) begin
                        // a write in the same cycle brings new data, so ack stays up
                        hs_next = wrA ? PPIO_HS_ACK : PPIO_HS_WAIT_LOW; // RULE_17
                        hsEvent = 1'b1;
                    end
                end else begin
                    hs_next = PPIO_HS_IDLE; // RULE_14
                end
            end
            PPIO_HS_WAIT_LOW: begin
                // a fresh write restarts the cycle even with the strobe still high
                if (modeOneOut && wrA) begin
                    hs_next = PPIO_HS_ACK;
                end else if (!latchHigh || !modeOneOut) begin
                    hs_next = PPIO_HS_IDLE;
                end
            end
            default: begin
                hs_next = PPIO_HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hs_reg <= PPIO_HS_IDLE;
            ackOut <= 1'b0;
        end else begin
            hs_reg <= hs_next;
            ackOut <= (hs_next == PPIO_HS_ACK); // RULE_15
        end
    end

    // interrupt request: a new event wins over a same-cycle clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_reg <= 1'b0;
        end else if (hsEvent) begin
            irq_reg <= 1'b1;
        end else if (intClear) begin
            irq_reg <= 1'b0; // RULE_18
        end
    end

    // input halves read pins; output halves read back what was written
    assign cReadVal = {cfg_reg.dirCUpper ? pinSync2_reg.portCLines[7:4] : portCOut_reg[7:4],
                       cfg_reg.dirCLower ? pinSync2_reg.portCLines[3:0] : portCOut_reg[3:0]};

    // read multiplexer; unmapped and off-page offsets read as zero
    always_comb begin
        readVal = `PPIO_DATA_RESET;
        if (busAddr == `PPIO_OFS_PAGE_READ) begin
            readVal = {5'h00, page_reg}; // RULE_05
        end else if (pageSel) begin
            case (busAddr)
                `PPIO_OFS_PORT_A: begin
                    // mode 1 input returns the strobe-captured byte, not the live pins
                    if (!cfg_reg.port_a_direction) begin
                        readVal = portAOut_reg; // RULE_19
                    end else if (cfg_reg.port_a_mode_select) begin
                        readVal = portALatched_reg;
                    end else begin
                        readVal = pinSync2_reg.portALines; // RULE_14
                    end
                end
                `PPIO_OFS_PORT_B: begin
                    readVal = cfg_reg.port_b_direction ? pinSync2_reg.portBLines : portBOut_reg;
                end
                `PPIO_OFS_PORT_C: begin
                    readVal = cReadVal; // RULE_06
                end
                default: begin
                    readVal = `PPIO_DATA_RESET; // RULE_10
                end
            endcase
        end
    end

    // the answer holds until the next read strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_reg <= `PPIO_DATA_RESET;
        end else if (busRead) begin
            rdata_reg <= readVal;
        end
    end

    // pin enables; low while the line drives, one cycle behind the config byte
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            oe_reg <= '1; // RULE_08
        end else begin
            oe_reg.portALines <= {8{cfg_reg.port_a_direction}}; // RULE_07 RULE_11
            oe_reg.portBLines <= {8{cfg_reg.port_b_direction}};
            oe_reg.portCLines <= {{4{cfg_reg.dirCUpper}}, {4{cfg_reg.dirCLower}}}; // RULE_06
        end
    end

    // drive values go to every line; only the enable decides what reaches a pin
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            linesOut <= '0;
        end else begin
            linesOut <= {portAOut_reg, portBOut_reg, portCOut_reg}; // RULE_19
        end
    end

    assign busRdata = rdata_reg;
    assign linesOe_n = oe_reg;
    assign irqOut = irq_reg;
    assign boardResetPulse = boardReset_reg;
    assign pageOut = page_reg;
endmodule : ppio_ports

// ### rtl/ppio_regs.svh
// register offsets, field positions and reset values of the paged parallel ports
`ifndef PPIO_REGS_SVH
`define PPIO_REGS_SVH
`define PPIO_OFS_PAGE_READ 4'h7
`define PPIO_OFS_MISC_CTRL 4'h8
`define PPIO_OFS_PORT_A 4'hc
`define PPIO_OFS_PORT_B 4'hd
`define PPIO_OFS_PORT_C 4'he
`define PPIO_OFS_CONFIG 4'hf
`define PPIO_PAGE_PORTS 3'h1
`define PPIO_PAGE_RESET 3'h0
`define PPIO_MISC_PAGE_LSB 0
`define PPIO_MISC_PAGE_MSB 2
`define PPIO_MISC_INT_CLEAR 3
`define PPIO_MISC_BOARD_RESET 5
`define PPIO_CFG_SET 7
`define PPIO_CFG_MODE_C 6
`define PPIO_CFG_MODE_A 5
`define PPIO_CFG_DIR_A 4
`define PPIO_CFG_DIR_CU 3
`define PPIO_CFG_MODE_B 2
`define PPIO_CFG_DIR_B 1
`define PPIO_CFG_DIR_CL 0
`define PPIO_CFG_RESET 8'h9b
`define PPIO_DATA_RESET 8'h00
`endif

// ### test/ppio_ext.sv
// external circuit on the header: drives lines it owns, pull-ups elsewhere
`timescale 1ns/1ps
module ppio_ext (
    input wire ppio_pkg::ppio_lines_s linesOut,
    input wire ppio_pkg::ppio_lines_s linesOe_n,
    input wire logic [23:0] extVal,
    input wire logic [23:0] extOe_n,
    output ppio_pkg::ppio_lines_s linesIn
);
    import ppio_pkg::*;
    // a driven device line wins over the circuit; released lines float up
    assign linesIn = ppio_lines_s'((~linesOe_n & linesOut) | (linesOe_n & ~extOe_n & extVal)
        | (linesOe_n & extOe_n));
endmodule : ppio_ext

// ### test/ppio_ports_sva.sv
// assertion checker for the paged parallel port block
`timescale 1ns/1ps
module ppio_ports_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] busAddr,
    input wire logic busRead,
    input wire logic busWrite,
    input wire ppio_pkg::ppio_byte_t busWdata,
    input wire ppio_pkg::ppio_byte_t busRdata,
    input wire ppio_pkg::ppio_lines_s linesIn,
    input wire ppio_pkg::ppio_lines_s linesOut,
    input wire ppio_pkg::ppio_lines_s linesOe_n,
    input wire logic latchIn,
    input wire logic ackOut,
    input wire logic irqOut,
    input wire logic boardResetPulse,
    input wire logic [2:0] pageOut
);
    import ppio_pkg::*;
    ppio_byte_t cfg_reg;
    logic [1:0] cfgAge_reg;
    logic cfgWr;
    logic oeOk;
    assign cfgWr = busWrite && busAddr == 4'hf && busWdata[7] && pageOut == 3'h1;
    assign oeOk = linesOe_n == {{8{cfg_reg[4]}}, {8{cfg_reg[1]}}, {4{cfg_reg[3]}}, {4{cfg_reg[0]}}};
    // shadow of the accepted config byte; pins are allowed to lag it a little
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_reg <= 8'h9b;
        end else if (cfgWr) begin
            cfg_reg <= busWdata;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfgAge_reg <= 2'h3;
        end else if (cfgWr) begin
            cfgAge_reg <= 2'h0;
        end else if (cfgAge_reg != 2'h3) begin
            cfgAge_reg <= cfgAge_reg + 2'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_page_decode: assert property (
        busRead && busAddr >= 4'hc && pageOut != 3'h1 |=> busRdata == 8'h00) else $error("off page read");
    a_page_readback: assert property (
        busRead && busAddr == 4'h7 |=> busRdata == {5'h00, $past(pageOut)}) else $error("page read");
    a_page_write: assert property (
        busWrite && busAddr == 4'h8 && busWdata[5:3] == 3'h0
        |=> pageOut == $past(busWdata[2:0]) && !boardResetPulse) else $error("page write");
    a_page_kept: assert property (
        busWrite && busAddr == 4'h8 && (busWdata[5] || busWdata[3]) |=> $stable(pageOut))
        else $error("page changed");
    a_oe_follow: assert property (cfgAge_reg == 2'h3 |-> oeOk) else $error("oe mismatch");
    a_ack_write: assert property (
        busWrite && busAddr == 4'hc && pageOut == 3'h1 && cfg_reg[5:4] == 2'b10 |=> ackOut)
        else $error("no ack on write");
    a_irq_hold: assert property (
        irqOut && !(busWrite && busAddr == 4'h8 && busWdata[3]) |=> irqOut) else $error("irq lost");
    a_irq_clear: assert property (
        !latchIn [*4] ##1 (!latchIn && busWrite && busAddr == 4'h8 && busWdata[3]) |=> !irqOut)
        else $error("irq not cleared");
endmodule : ppio_ports_sva
bind ppio_ports ppio_ports_sva u_sva (.clk, .reset, .busAddr, .busRead, .busWrite, .busWdata,
    .busRdata, .linesIn, .linesOut, .linesOe_n, .latchIn, .ackOut, .irqOut,
    .boardResetPulse, .pageOut);

// ### test/tb_paged_parallel_io_ports.sv
// self-checking bench for the paged parallel port block
`timescale 1ns/1ps
module tb_paged_parallel_io_ports;
    import ppio_pkg::*;
    logic clk = 1'b0, reset = 1'b1, busRead = 1'b0, busWrite = 1'b0, latchIn = 1'b0;
    logic [3:0] busAddr = 4'h0;
    ppio_byte_t busWdata = 8'h00, busRdata;
    ppio_lines_s linesIn, linesOut, linesOe_n;
    logic [23:0] extVal = 24'h000000, extOe_n = 24'hffffff;
    logic ackOut, irqOut, boardResetPulse;
    logic [2:0] pageOut;
    int n_fail = 0, cmp_count = 0;
    always #2 clk = ~clk;
    ppio_ports dut (.clk, .reset, .busAddr, .busRead, .busWrite, .busWdata, .busRdata,
        .linesIn, .linesOut, .linesOe_n, .latchIn, .ackOut, .irqOut, .boardResetPulse, .pageOut);
    ppio_ext ext (.linesOut, .linesOe_n, .extVal, .extOe_n, .linesIn);
    task automatic test_done();
        $display("mismatches %0d of %0d compares", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(string name, logic [23:0] seen, logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        busAddr <= a;
        busWdata <= d;
        busWrite <= 1'b1;
        @(posedge clk);
        busWrite <= 1'b0;
    endtask : wr
    task automatic rd(string name, logic [3:0] a, logic [7:0] exp);
        @(posedge clk);
        busAddr <= a;
        busRead <= 1'b1;
        @(posedge clk);
        busRead <= 1'b0;
        @(posedge clk);
        #1 chk(name, {16'h0, busRdata}, {16'h0, exp});
    endtask : rd
    task automatic wait_ack(logic v);
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (ackOut === v) return;
        end
        n_fail++;
        test_done();
    endtask : wait_ack
    task automatic t_page();
        chk("oe at reset", linesOe_n, 24'hffffff);
        rd("page", 4'h7, 8'h00);
        wr(4'h8, 8'h01);
        #1 chk("page pin", {21'h0, pageOut}, 24'h1);
        chk("no board reset", {23'h0, boardResetPulse}, 24'h0);
        rd("page", 4'h7, 8'h01);
        wr(4'h8, 8'h2a);
        #1 chk("board reset", {23'h0, boardResetPulse}, 24'h1);
        chk("page pin kept", {21'h0, pageOut}, 24'h1);
        rd("page kept", 4'h7, 8'h01);
    endtask : t_page
    task automatic t_cfg();
        logic [7:0] tbl[6] = '{8'h9b, 8'h92, 8'h93, 8'h99, 8'h8b, 8'h80};
        logic [7:0] c;
        foreach (tbl[i]) begin
            c = tbl[i];
            wr(4'hf, c);
            repeat (3) @(posedge clk);
            #1 chk("oe", linesOe_n, {{8{c[4]}}, {8{c[1]}}, {4{c[3]}}, {4{c[0]}}});
        end
        wr(4'hf, 8'h1b);
        repeat (3) @(posedge clk);
        #1 chk("oe unset", linesOe_n, 24'h000000);
        rd("cfg", 4'hf, 8'h00);
    endtask : t_cfg
    task automatic t_data();
        wr(4'hc, 8'ha5);
        wr(4'hd, 8'h3c);
        wr(4'he, 8'h71);
        repeat (3) @(posedge clk);
        #1 chk("pins", linesOut, 24'ha53c71);
        rd("port c", 4'he, 8'h71);
        wr(4'h8, 8'h02);
        rd("off page", 4'hc, 8'h00);
        wr(4'h8, 8'h01);
        @(posedge clk);
        extVal <= 24'h5a0f96;
        extOe_n <= 24'h000000;
        latchIn <= 1'b1;
        wr(4'hf, 8'h9b);
        wr(4'hd, 8'hff);
        repeat (3) @(posedge clk);
        rd("pins a", 4'hc, 8'h5a);
        rd("pins b", 4'hd, 8'h0f);
        rd("pins c", 4'he, 8'h96);
        wr(4'hf, 8'h9a);
        rd("split c", 4'he, 8'h91);
        chk("mode 0 ack", {23'h0, ackOut}, 24'h0);
        @(posedge clk);
        latchIn <= 1'b0;
    endtask : t_data
    task automatic t_m1_in();
        wr(4'hf, 8'hb0);
        @(posedge clk);
        extVal <= 24'hc30000;
        latchIn <= 1'b1;
        wait_ack(1'b1);
        chk("irq", {23'h0, irqOut}, 24'h1);
        @(posedge clk);
        latchIn <= 1'b0;
        extVal <= 24'h110000;
        rd("latched", 4'hc, 8'hc3);
        chk("ack read", {23'h0, ackOut}, 24'h0);
        chk("irq held", {23'h0, irqOut}, 24'h1);
        rd("latch cleared", 4'hc, 8'h00);
        repeat (5) @(posedge clk);
        wr(4'h8, 8'h09);
        @(posedge clk);
        #1 chk("irq clear", {23'h0, irqOut}, 24'h0);
    endtask : t_m1_in
    task automatic t_m1_out();
        wr(4'hf, 8'ha0);
        wr(4'hc, 8'h3c);
        #1 chk("ack write", {23'h0, ackOut}, 24'h1);
        @(posedge clk);
        latchIn <= 1'b1;
        wait_ack(1'b0);
        @(posedge clk);
        latchIn <= 1'b0;
        #1 chk("irq", {23'h0, irqOut}, 24'h1);
        repeat (5) @(posedge clk);
        wr(4'h8, 8'h09);
        @(posedge clk);
        #1 chk("irq clear", {23'h0, irqOut}, 24'h0);
    endtask : t_m1_out
    task automatic t_reset();
        wr(4'hc, 8'h55);
        #1 chk("ack before reset", {23'h0, ackOut}, 24'h1);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("oe reset", linesOe_n, 24'hffffff);
        chk("lines reset", linesOut, 24'h000000);
        chk("ack reset", {23'h0, ackOut}, 24'h0);
        chk("page reset", {21'h0, pageOut}, 24'h0);
        @(posedge clk);
        reset <= 1'b0;
        rd("page after reset", 4'h7, 8'h00);
    endtask : t_reset
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        t_page();
        t_cfg();
        t_data();
        t_m1_in();
        t_m1_out();
        t_reset();
        test_done();
    end
endmodule : tb_paged_parallel_io_ports
